// >>> verilog/card_detect_pkg.sv
// Constants, register map and field layout of the card detection
// threshold unit. Assumes an 8-bit register port on a 125 MHz clock.
//
// Summary of operation
// - Bits 7 and 6 of the Q upper-border register hold bits 3 and 2 of the I upper threshold, read and write.
// - Bits 7 and 6 of the I lower-border register hold bits 1 and 0 of the I upper threshold, read and write.
// - An I measurement above the assembled I upper threshold raises the card detection interrupt.
// - The Q upper threshold sits in bits 5 to 0 and a Q measurement above it raises the interrupt.
// - The I lower threshold sits in bits 5 to 0 and an I measurement below it raises the interrupt.
// - The I result register shows the last I value in bits 5 to 0, read only, bits 7 and 6 reserved.
// - The Q result register shows the last Q value in bits 5 to 0, read only, bit 7 reserved.
// - While the suppress bit 6 of the Q result register is set, no interrupt is raised until the next procedure.
// - Option bit 3 selects full transmitter supply during detection, else a level reduced by 0.4 V.
// - Option bit 2 bases the decision on a noise filter over the samples, within 4.72 us of sampling.
// - Option bit 1 reports that the Q value changed while measuring, valid only with the filter on.
// - Option bit 0 reports that the I value changed while measuring, valid only with the filter on.
// - The option register at 3AH exists only on the newer variant, else reads as reserved; bits 7 to 4 reserved.
// - Bits 7 and 6 of the Q lower-border register hold bits 5 and 4 of the I upper threshold.
// - The Q lower border sits in bits 5 to 0 and detections show in the card detection interrupt flag.

`default_nettype none

package card_detect_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int THR_W  = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_OPTIONS  = 8'h3A;
  localparam logic [ADDR_W-1:0] OFS_Q_LOWER  = 8'h3F;
  localparam logic [ADDR_W-1:0] OFS_Q_UPPER  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_I_LOWER  = 8'h41;
  localparam logic [ADDR_W-1:0] OFS_I_RESULT = 8'h42;
  localparam logic [ADDR_W-1:0] OFS_Q_RESULT = 8'h43;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h49;

  // Field positions
  localparam int THR_LSB      = 0;
  localparam int THR_MSB      = 5;
  localparam int PAIR_LO      = 6;
  localparam int PAIR_HI      = 7;
  localparam int SUPPRESS_POS = 6;
  localparam int OPT_TX_FULL  = 3;
  localparam int OPT_FILTER   = 2;
  localparam int OPT_Q_UNST   = 1;
  localparam int OPT_I_UNST   = 0;
  localparam int STAT_DETECT  = 0;

  // Reset values
  localparam logic [THR_W-1:0]  THR_RST  = 6'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Sampling window: longest time, rounded down to whole cycles
  localparam real SAMPLE_TIME_US = 4.72;
  localparam real CLK_FREQ_MHZ   = 125.0;
  localparam int  SAMPLE_WIN_CYC =
    int'($floor(SAMPLE_TIME_US * CLK_FREQ_MHZ + 0.001));
  localparam int  WIN_W          = 10;

endpackage

`default_nettype wire

// >>> verilog/card_detect_eval_if.sv
// Carrier between the register unit and the sampling evaluator.
// Assumes both ends run on the same system clock.

`default_nettype none

interface card_detect_eval_if
  import card_detect_pkg::*;
();
  logic             start;
  logic             sample_valid;
  logic [THR_W-1:0] i_sample;
  logic [THR_W-1:0] q_sample;
  logic             finish;
  logic             filter_en;
  logic             done;
  logic [THR_W-1:0] i_value;
  logic [THR_W-1:0] q_value;
  logic             i_unstable;
  logic             q_unstable;

  modport ctrl (
    output start, sample_valid, i_sample, q_sample, finish, filter_en,
    input  done, i_value, q_value, i_unstable, q_unstable
  );
  modport eval (
    input  start, sample_valid, i_sample, q_sample, finish, filter_en,
    output done, i_value, q_value, i_unstable, q_unstable
  );
endinterface

`default_nettype wire

// >>> verilog/card_detect_sampler.sv
// Sampling evaluator: condenses the I and Q samples of one detection
// procedure into one value per channel, optionally through a filter.
// Assumes start and finish are one-cycle pulses, start before finish.

`default_nettype none

module card_detect_sampler
  import card_detect_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Evaluator side
  card_detect_eval_if.eval ev
);

  logic             active_q;
  logic             first_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic [THR_W-1:0] i_acc_q;
  logic [THR_W-1:0] q_acc_q;
  logic [THR_W-1:0] i_ref_q;
  logic [THR_W-1:0] q_ref_q;
  logic             i_chg_q;
  logic             q_chg_q;
  logic             take;
  logic [THR_W:0]   i_sum;
  logic [THR_W:0]   q_sum;

  // Samples past the window are dropped so the filter never
  // stretches the RF-on time
  assign take  = active_q && ev.sample_valid &&
                 (win_cnt_q < WIN_W'(SAMPLE_WIN_CYC));
  assign i_sum = {1'b0, i_acc_q} + {1'b0, ev.i_sample};
  assign q_sum = {1'b0, q_acc_q} + {1'b0, ev.q_sample};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_q  <= 1'b0;
      win_cnt_q <= '0;
    end else if (ev.start) begin
      active_q  <= 1'b1;
      win_cnt_q <= '0;
    end else if (ev.finish) begin
      active_q  <= 1'b0;
    end else if (active_q && win_cnt_q < WIN_W'(SAMPLE_WIN_CYC)) begin
      win_cnt_q <= win_cnt_q + WIN_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_q <= 1'b0;
      i_acc_q <= THR_RST;
      q_acc_q <= THR_RST;
      i_ref_q <= THR_RST;
      q_ref_q <= THR_RST;
      i_chg_q <= 1'b0;
      q_chg_q <= 1'b0;
    end else if (ev.start) begin
      first_q <= 1'b1;
      i_chg_q <= 1'b0;
      q_chg_q <= 1'b0;
    end else if (take) begin
      first_q <= 1'b0;
      if (first_q) begin
        i_acc_q <= ev.i_sample;
        q_acc_q <= ev.q_sample;
        i_ref_q <= ev.i_sample;
        q_ref_q <= ev.q_sample;
      end else if (ev.filter_en) begin
        // Running average of the accumulated value and each new sample smooths noise
        i_acc_q <= i_sum[THR_W:1];
        q_acc_q <= q_sum[THR_W:1];
        i_chg_q <= i_chg_q | (ev.i_sample != i_ref_q);
        q_chg_q <= q_chg_q | (ev.q_sample != q_ref_q);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev.done       <= 1'b0;
      ev.i_value    <= THR_RST;
      ev.q_value    <= THR_RST;
      ev.i_unstable <= 1'b0;
      ev.q_unstable <= 1'b0;
    end else begin
      ev.done <= ev.finish && active_q;
      if (ev.finish && active_q) begin
        ev.i_value    <= i_acc_q;
        ev.q_value    <= q_acc_q;
        ev.i_unstable <= i_chg_q && ev.filter_en;
        ev.q_unstable <= q_chg_q && ev.filter_en;
      end
    end
  end

endmodule

`default_nettype wire

// >>> verilog/card_detect_threshold_unit.sv
// Register unit of the low-power card detection: thresholds, results,
// options, interrupt status and mask, and the border comparison.
// Assumes a single-cycle register port and same-clock sample inputs.
//
// The plain strobed port was chosen for this implementation.

`default_nettype none

module card_detect_threshold_unit
  import card_detect_pkg::*;
#(
  parameter bit NEWER_VARIANT = 1'b1
)(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Measurement front end
  input  wire logic              detect_start,
  input  wire logic              sample_valid,
  input  wire logic [THR_W-1:0]  i_sample,
  input  wire logic [THR_W-1:0]  q_sample,
  input  wire logic              detect_finish,
  // Controls and interrupt
  output logic                   tx_full_supply_select,
  output logic                   detect_noise_filter_en,
  output logic                   card_detect_irq_flag,
  output logic                   irq
);

  // The register layout packs six-bit fields; other widths cannot fit
  if (THR_W != 6) begin : g_thr_chk
    $error("threshold width must be 6");
  end
  if (SAMPLE_WIN_CYC >= (1 << WIN_W)) begin : g_win_chk
    $error("window counter too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // Evaluator

  card_detect_eval_if ev ();

  assign ev.start        = detect_start;
  assign ev.sample_valid = sample_valid;
  assign ev.i_sample     = i_sample;
  assign ev.q_sample     = q_sample;
  assign ev.finish       = detect_finish;
  assign ev.filter_en    = detect_noise_filter_en;

  card_detect_sampler u_sampler (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ev      (ev.eval)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register state

  logic [THR_W-1:0] i_upper_threshold_q;
  logic [THR_W-1:0] q_upper_threshold_q;
  logic [THR_W-1:0] i_lower_threshold_q;
  logic [THR_W-1:0] q_lower_threshold_q;
  logic [THR_W-1:0] i_detect_result_q;
  logic [THR_W-1:0] q_detect_result_q;
  logic             detect_irq_suppress_q;
  logic             i_channel_unstable_q;
  logic             q_channel_unstable_q;
  logic             irq_mask_q;
  logic             hit;
  logic             raise;
  logic             wr_opt;
  logic             wr_qres;
  logic             wr_stat;
  logic [DATA_W-1:0] rd_mux;

  assign wr_opt  = reg_wr && reg_addr == OFS_OPTIONS && NEWER_VARIANT;
  assign wr_qres = reg_wr && reg_addr == OFS_Q_RESULT;
  assign wr_stat = reg_wr && reg_addr == OFS_IRQ_STAT;

  // I upper threshold is spread over the top pairs of three registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i_upper_threshold_q <= THR_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_Q_LOWER) begin
        i_upper_threshold_q[5:4] <= reg_wdata[PAIR_HI:PAIR_LO];
      end else if (reg_addr == OFS_Q_UPPER) begin
        i_upper_threshold_q[3:2] <= reg_wdata[PAIR_HI:PAIR_LO];
      end else if (reg_addr == OFS_I_LOWER) begin
        i_upper_threshold_q[1:0] <= reg_wdata[PAIR_HI:PAIR_LO];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_lower_threshold_q <= THR_RST;
      q_upper_threshold_q <= THR_RST;
      i_lower_threshold_q <= THR_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_Q_LOWER) begin
        q_lower_threshold_q <= reg_wdata[THR_MSB:THR_LSB];
      end
      if (reg_addr == OFS_Q_UPPER) begin
        q_upper_threshold_q <= reg_wdata[THR_MSB:THR_LSB];
      end
      if (reg_addr == OFS_I_LOWER) begin
        i_lower_threshold_q <= reg_wdata[THR_MSB:THR_LSB];
      end
    end
  end

  // Option bits are absent on the older variant
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_full_supply_select  <= 1'b0;
      detect_noise_filter_en <= 1'b0;
    end else if (wr_opt) begin
      tx_full_supply_select  <= reg_wdata[OPT_TX_FULL];
      detect_noise_filter_en <= reg_wdata[OPT_FILTER];
    end
  end

  // Results and instability flags change only at procedure end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      i_detect_result_q    <= THR_RST;
      q_detect_result_q    <= THR_RST;
      i_channel_unstable_q <= 1'b0;
      q_channel_unstable_q <= 1'b0;
    end else if (ev.done) begin
      i_detect_result_q    <= ev.i_value;
      q_detect_result_q    <= ev.q_value;
      i_channel_unstable_q <= ev.i_unstable;
      q_channel_unstable_q <= ev.q_unstable;
    end
  end

  // Suppress lasts until the next procedure starts; a software set
  // in that same cycle wins so the request is not lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      detect_irq_suppress_q <= 1'b0;
    end else if (wr_qres) begin
      detect_irq_suppress_q <= reg_wdata[SUPPRESS_POS];
    end else if (detect_start) begin
      detect_irq_suppress_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison and interrupt

  // One evaluation per procedure, on the evaluator's done pulse
  assign hit = (ev.i_value > i_upper_threshold_q) ||
               (ev.q_value > q_upper_threshold_q) ||
               (ev.i_value < i_lower_threshold_q) ||
               (ev.q_value < q_lower_threshold_q);
  assign raise = ev.done && hit && !detect_irq_suppress_q;

  // Sticky flag, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      card_detect_irq_flag <= 1'b0;
    end else if (raise) begin
      card_detect_irq_flag <= 1'b1;
    end else if (wr_stat && reg_wdata[STAT_DETECT]) begin
      card_detect_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[STAT_DETECT];
    end
  end

  // Registered output; rises with the flag on a raise, falls one cycle after the flag clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (card_detect_irq_flag || raise) && irq_mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rd_mux = DATA_ZERO;
    case (reg_addr)
      OFS_OPTIONS: begin
        if (NEWER_VARIANT) begin
          rd_mux[OPT_TX_FULL] = tx_full_supply_select;
          rd_mux[OPT_FILTER]  = detect_noise_filter_en;
          rd_mux[OPT_Q_UNST]  = q_channel_unstable_q;
          rd_mux[OPT_I_UNST]  = i_channel_unstable_q;
        end
      end
      OFS_Q_LOWER: begin
        rd_mux[PAIR_HI:PAIR_LO] = i_upper_threshold_q[5:4];
        rd_mux[THR_MSB:THR_LSB] = q_lower_threshold_q;
      end
      OFS_Q_UPPER: begin
        rd_mux[PAIR_HI:PAIR_LO] = i_upper_threshold_q[3:2];
        rd_mux[THR_MSB:THR_LSB] = q_upper_threshold_q;
      end
      OFS_I_LOWER: begin
        rd_mux[PAIR_HI:PAIR_LO] = i_upper_threshold_q[1:0];
        rd_mux[THR_MSB:THR_LSB] = i_lower_threshold_q;
      end
      OFS_I_RESULT: begin
        rd_mux[THR_MSB:THR_LSB] = i_detect_result_q;
      end
      OFS_Q_RESULT: begin
        rd_mux[SUPPRESS_POS]    = detect_irq_suppress_q;
        rd_mux[THR_MSB:THR_LSB] = q_detect_result_q;
      end
      OFS_IRQ_STAT: begin
        rd_mux[STAT_DETECT] = card_detect_irq_flag;
      end
      OFS_IRQ_MASK: begin
        rd_mux[STAT_DETECT] = irq_mask_q;
      end
      default: begin
        rd_mux = DATA_ZERO;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= DATA_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_iupper_pair_read: assert property (
    reg_rd && reg_addr == OFS_Q_UPPER |=>
      reg_rdata[PAIR_HI:PAIR_LO] == $past(i_upper_threshold_q[3:2]))
    else $error("I upper bits 3:2 misplaced");

  a_iupper_low_write: assert property (
    reg_wr && reg_addr == OFS_I_LOWER |=>
      i_upper_threshold_q[1:0] == $past(reg_wdata[PAIR_HI:PAIR_LO]))
    else $error("I upper bits 1:0 not written");

  a_iupper_raise: assert property (
    ev.done && ev.i_value > i_upper_threshold_q &&
      !detect_irq_suppress_q |=> card_detect_irq_flag)
    else $error("I over border did not raise flag");

  a_result_readback: assert property (
    reg_rd && reg_addr == OFS_I_RESULT |=>
      reg_rdata == {2'b00, $past(i_detect_result_q)})
    else $error("I result not shown");

  a_suppress_blocks: assert property (
    detect_irq_suppress_q && !card_detect_irq_flag &&
      ev.done |=> !card_detect_irq_flag)
    else $error("flag raised while suppressed");

  a_suppress_ends: assert property (
    detect_start && !wr_qres |=> !detect_irq_suppress_q)
    else $error("suppress survived a new procedure");

  a_unstable_gated: assert property (
    ev.done && !detect_noise_filter_en |=>
      !q_channel_unstable_q && !i_channel_unstable_q)
    else $error("instability reported with filter off");

  a_old_variant_zero: assert property (
    reg_rd && reg_addr == OFS_OPTIONS && !NEWER_VARIANT |=>
      reg_rdata == DATA_ZERO)
    else $error("option register visible on old variant");

  a_options_reserved: assert property (
    reg_rd && reg_addr == OFS_OPTIONS |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved option bits not zero");

  a_results_hold: assert property (
    !ev.done |=> $stable(i_detect_result_q) && $stable(q_detect_result_q))
    else $error("result changed outside procedure end");

  a_irq_follows: assert property (
    card_detect_irq_flag && irq_mask_q ##1 card_detect_irq_flag |-> irq)
    else $error("interrupt output not following flag");

  a_iupper_high_write: assert property (
    reg_wr && reg_addr == OFS_Q_LOWER |=>
      i_upper_threshold_q[5:4] == $past(reg_wdata[PAIR_HI:PAIR_LO]))
    else $error("I upper bits 5:4 not written");

  a_iupper_mid_write: assert property (
    reg_wr && reg_addr == OFS_Q_UPPER |=>
      i_upper_threshold_q[3:2] == $past(reg_wdata[PAIR_HI:PAIR_LO]))
    else $error("I upper bits 3:2 not written");

  a_qupper_raise: assert property (
    ev.done && ev.q_value > q_upper_threshold_q &&
      !detect_irq_suppress_q |=> card_detect_irq_flag)
    else $error("Q over border did not raise flag");

  a_ilower_raise: assert property (
    ev.done && ev.i_value < i_lower_threshold_q &&
      !detect_irq_suppress_q |=> card_detect_irq_flag)
    else $error("I under border did not raise flag");

  a_qlower_raise: assert property (
    ev.done && ev.q_value < q_lower_threshold_q &&
      !detect_irq_suppress_q |=> card_detect_irq_flag)
    else $error("Q under border did not raise flag");

  a_result_capture: assert property (
    ev.done |=> i_detect_result_q == $past(ev.i_value) &&
      q_detect_result_q == $past(ev.q_value))
    else $error("results not taken at procedure end");

  a_qresult_read: assert property (
    reg_rd && reg_addr == OFS_Q_RESULT |=>
      reg_rdata == {1'b0, $past(detect_irq_suppress_q),
                    $past(q_detect_result_q)})
    else $error("Q result register misread");

  a_tx_option_write: assert property (
    wr_opt |=> tx_full_supply_select == $past(reg_wdata[OPT_TX_FULL]))
    else $error("transmitter level option not written");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == DATA_ZERO)
    else $error("read data stand outside the read cycle");

endmodule

`default_nettype wire

// >>> test/card_detect_threshold_unit_tb_top.sv
// Self-checking bench for the card detection threshold unit.
// Assumes the package constants and both register map variants.
`default_nettype none

module card_detect_threshold_unit_tb_top
  import card_detect_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk_sys, rst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, old_rdata;
  logic              detect_start, sample_valid, detect_finish;
  logic [THR_W-1:0]  i_sample, q_sample;
  logic              tx_sel, filt_en, flag_pin, irq;
  int                fails, total_checks;
  // Reference model state
  bit   [7:0]        r3f, r40, r41;
  bit   [1:0]        m_opt;
  bit   [5:0]        m_ires, m_qres;
  bit                m_iun, m_qun, m_supp, m_flag, m_mask;
  logic [7:0]        addrs [9] = '{8'h3A, 8'h3F, 8'h40, 8'h41, 8'h42,
                                   8'h43, 8'h48, 8'h49, 8'h50};
  bit   [5:0]        ti [8] = '{30, 39, 38, 30, 30, 11, 12, 30};
  bit   [5:0]        tq [8] = '{30, 30, 30, 51, 50, 30, 30, 9};

  card_detect_threshold_unit #(.NEWER_VARIANT(1'b1))
    card_detect_threshold_unit_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .detect_start(detect_start),
    .sample_valid(sample_valid), .i_sample(i_sample),
    .q_sample(q_sample), .detect_finish(detect_finish),
    .tx_full_supply_select(tx_sel), .detect_noise_filter_en(filt_en),
    .card_detect_irq_flag(flag_pin), .irq(irq));

  // Older variant only serves to show the option address as reserved
  card_detect_threshold_unit #(.NEWER_VARIANT(1'b0)) old_variant_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(old_rdata), .detect_start(detect_start),
    .sample_valid(sample_valid), .i_sample(i_sample),
    .q_sample(q_sample), .detect_finish(detect_finish),
    .tx_full_supply_select(), .detect_noise_filter_en(),
    .card_detect_irq_flag(), .irq());

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_reg(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_bit(input string n, input logic e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      OFS_OPTIONS:  exp_rd = {4'h0, m_opt, m_qun, m_iun};
      OFS_Q_LOWER:  exp_rd = r3f;
      OFS_Q_UPPER:  exp_rd = r40;
      OFS_I_LOWER:  exp_rd = r41;
      OFS_I_RESULT: exp_rd = {2'b00, m_ires};
      OFS_Q_RESULT: exp_rd = {1'b0, m_supp, m_qres};
      OFS_IRQ_STAT: exp_rd = {7'h00, m_flag};
      OFS_IRQ_MASK: exp_rd = {7'h00, m_mask};
      default:      exp_rd = 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    case (a)
      OFS_OPTIONS:  m_opt = d[3:2];
      OFS_Q_LOWER:  r3f = d;
      OFS_Q_UPPER:  r40 = d;
      OFS_I_LOWER:  r41 = d;
      OFS_Q_RESULT: m_supp = d[6];
      OFS_IRQ_STAT: m_flag = m_flag & ~d[0];
      OFS_IRQ_MASK: m_mask = d[0];
      default:      ;
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check_reg($sformatf("reg %h", a), exp_rd(a), reg_rdata);
    if (a == OFS_OPTIONS) begin
      check_reg("old option reg", 8'h00, old_rdata);
    end
  endtask

  task automatic irq_chk();
    @(posedge clk_sys);
    #1;
    check_bit("flag pin", m_flag, flag_pin);
    check_bit("irq", m_flag & m_mask, irq);
  endtask

  task automatic detect(input bit [5:0] i0, q0, i1, q1, input int n,
                        input bit supp);
    bit [5:0] vi, vq;
    @(posedge clk_sys);
    detect_start <= 1'b1;
    @(posedge clk_sys);
    detect_start <= 1'b0;
    m_supp = 1'b0;
    sample_valid <= 1'b1;
    i_sample     <= i0;
    q_sample     <= q0;
    if (n > 1) begin
      @(posedge clk_sys);
      i_sample <= i1;
      q_sample <= q1;
    end
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    i_sample     <= 6'($urandom);
    q_sample     <= 6'($urandom);
    if (supp) begin
      wr(OFS_Q_RESULT, 8'h40);
    end
    @(posedge clk_sys);
    detect_finish <= 1'b1;
    @(posedge clk_sys);
    detect_finish <= 1'b0;
    vi = i0;
    vq = q0;
    m_iun = m_opt[0] && n > 1 && i1 != i0;
    m_qun = m_opt[0] && n > 1 && q1 != q0;
    if (m_opt[0] && n > 1) begin
      vi = 6'((7'(vi) + 7'(i1)) >> 1);
      vq = 6'((7'(vq) + 7'(q1)) >> 1);
    end
    m_ires = vi;
    m_qres = vq;
    if (!m_supp && (vi > {r3f[7:6], r40[7:6], r41[7:6]} ||
        vq > r40[5:0] || vi < r41[5:0] || vq < r3f[5:0])) begin
      m_flag = 1'b1;
    end
    repeat (2) @(posedge clk_sys);
    irq_chk();
  endtask

  task automatic read_results();
    rd_chk(OFS_I_RESULT);
    rd_chk(OFS_Q_RESULT);
    rd_chk(OFS_IRQ_STAT);
    rd_chk(OFS_OPTIONS);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, detect_start, sample_valid, detect_finish} = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    i_sample  = '0;
    q_sample  = '0;
    void'($urandom(33));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (addrs[k]) rd_chk(addrs[k]);
    // Random data into every address, reserved and read-only ones too
    repeat (6) begin
      foreach (addrs[k]) begin
        wr(addrs[k], 8'($urandom));
        rd_chk(addrs[k]);
      end
      #1;
      check_bit("tx supply", m_opt[1], tx_sel);
      check_bit("filter en", m_opt[0], filt_en);
    end
    // I upper threshold 6'b100110 = 38 assembled from three registers
    wr(OFS_Q_LOWER, 8'h8A);
    wr(OFS_Q_UPPER, 8'h72);
    wr(OFS_I_LOWER, 8'h8C);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_OPTIONS, 8'h00);
    wr(OFS_IRQ_STAT, 8'h01);
    // Each border just crossed, and all but the Q lower border just not crossed
    foreach (ti[k]) begin
      detect(ti[k], tq[k], 6'h00, 6'h00, 1, 1'b0);
      read_results();
      wr(OFS_IRQ_STAT, 8'h01);
      irq_chk();
    end
    wr(OFS_IRQ_MASK, 8'h00);
    detect(6'd39, 6'd30, 6'h00, 6'h00, 1, 1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    irq_chk();
    wr(OFS_IRQ_STAT, 8'h01);
    // Suppress holds off one procedure, the next start releases it
    detect(6'd39, 6'd30, 6'h00, 6'h00, 1, 1'b1);
    rd_chk(OFS_Q_RESULT);
    detect(6'd39, 6'd30, 6'h00, 6'h00, 1, 1'b0);
    rd_chk(OFS_Q_RESULT);
    wr(OFS_IRQ_STAT, 8'h01);
    wr(OFS_OPTIONS, 8'h0C);
    detect(6'd20, 6'd30, 6'd40, 6'd30, 2, 1'b0);
    read_results();
    repeat (8) begin
      wr(OFS_OPTIONS, 8'($urandom));
      detect(6'($urandom), 6'($urandom), 6'($urandom), 6'($urandom),
             1 + ($urandom % 2), 1'b0);
      read_results();
      wr(OFS_IRQ_STAT, 8'h01);
    end
    finish_test();
  end
endmodule

`default_nettype wire
